// *** verilog/gtc_core.sv ***
// Functional notes
// - Run clear stops the timer; gate enable limits counting to gate-allowed periods.
// - Sixteen-bit up-counter as two bytes; byte writes land in the live count.
// - Source 01 is oscillator, 00 instruction clock, 10 pin or crystal.
// - Crystal oscillator is shared; each enable selects it for its own timer.
// - Oscillator source advances once per oscillator period, four per instruction.
// - Oscillator-source reads carry two LSB uncertainty unless gated asynchronously.
// - External source counts rising pin edges, synchronised or not.
// - First counted rising edge needs a prior low after enable, write or disable.
// - Prescaler divides by 1, 2, 4 or 8 and is hidden from software.
// - Any write to a count byte clears the prescaler.
// - Oscillator runs on any enable, force-run, or system select 01; survives sleep.
// - Bypass skips the synchroniser alignment stage for external edges.
// - Bypass with external source keeps counting in sleep; overflow wakes.
// - Switching sync mode may lose or add one increment.
// - With gate enable, count only while gate level equals polarity.
//
// Design decisions made here: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

module gtc_core
	import gtc_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	input wire logic [`GTC_ADDR_W-1:0] reg_addr,
	input wire logic [`GTC_DATA_W-1:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [`GTC_DATA_W-1:0] reg_rdata,
	input wire logic external_count_pin,
	input wire logic crystal_input_pin,
	input wire logic gate_pin,
	input wire logic comparator_gate,
	input wire logic sleep_mode,
	input wire logic [1:0] other_secondary_osc_enable,
	output logic crystal_output_pin,
	output logic secondary_osc_run,
	output logic overflow_flag,
	output logic wake_request
);

	// ****************************************
	// Declarations
	// ****************************************
	logic [`GTC_SYNC_W-1:0] sync1_reg;
	logic [`GTC_SYNC_W-1:0] sync1_next;
	logic [`GTC_SYNC_W-1:0] sync2_reg;
	logic [`GTC_SYNC_W-1:0] sync2_next;
	logic ext_prev_reg;
	logic ext_prev_next;
	logic ext_edge_d_reg;
	logic ext_edge_d_next;

	logic [`GTC_DATA_W-1:0] timer_control_reg;
	logic [`GTC_DATA_W-1:0] timer_control_next;
	logic [`GTC_DATA_W-1:0] gate_control_reg;
	logic [`GTC_DATA_W-1:0] gate_control_next;
	logic [1:0] system_clock_select_reg;
	logic [1:0] system_clock_select_next;
	logic force_run_reg;
	logic force_run_next;

	logic [15:0] count_reg;
	logic [15:0] count_next;
	logic [1:0] phase_reg;
	logic [1:0] phase_next;
	logic armed_reg;
	logic armed_next;
	logic overflow_reg;
	logic overflow_next;

	logic [`GTC_DATA_W-1:0] rdata_reg;
	logic [`GTC_DATA_W-1:0] rdata_next;
	logic wake_reg;
	logic wake_next;
	logic osc_run_reg;
	logic osc_run_next;
	logic xtal_out_reg;
	logic xtal_out_next;

	logic wr_low;
	logic wr_high;
	logic wr_count;
	logic wr_status;
	logic timer_run;
	logic gate_enable_mode;
	logic gate_polarity;
	logic secondary_osc_enable;
	logic sync_bypass;
	gtc_clk_src_t clock_source_select;
	logic ext_level;
	logic ext_edge;
	logic ext_edge_ok;
	logic gate_level;
	logic gate_ok;
	logic count_enable;
	logic instr_tick;
	logic src_tick;
	logic ovf_event;

	gtc_presc_if presc_bus ();

	function automatic logic reg_hit(input logic [`GTC_ADDR_W-1:0] addr, input logic [`GTC_ADDR_W-1:0] target);
		reg_hit = (addr == target);
	endfunction

	// ****************************************
	// Field views and write decode
	// ****************************************
	assign timer_run = timer_control_reg[`GTC_TC_RUN];
	assign sync_bypass = timer_control_reg[`GTC_TC_SYNC_BYPASS];
	assign secondary_osc_enable = timer_control_reg[`GTC_TC_SOSC_EN];
	assign clock_source_select = gtc_clk_src_t'(timer_control_reg[`GTC_TC_CS_MSB:`GTC_TC_CS_LSB]);
	assign gate_enable_mode = gate_control_reg[`GTC_GC_ENABLE];
	assign gate_polarity = gate_control_reg[`GTC_GC_POLARITY];
	assign wr_low = reg_write && reg_hit(reg_addr, `GTC_ADDR_COUNT_LOW);
	assign wr_high = reg_write && reg_hit(reg_addr, `GTC_ADDR_COUNT_HIGH);
	assign wr_status = reg_write && reg_hit(reg_addr, `GTC_ADDR_STATUS);
	assign wr_count = wr_low || wr_high;

	// ****************************************
	// Pin synchronisers and edge detect
	// ****************************************
	always_comb begin
		sync1_next = {comparator_gate, gate_pin, crystal_input_pin, external_count_pin};
		sync2_next = sync1_reg;
		// Crystal replaces the pin only for this timer
		ext_level = secondary_osc_enable ? sync2_reg[`GTC_SYNC_XTAL] : sync2_reg[`GTC_SYNC_PIN];
		ext_edge = ext_level && !ext_prev_reg;
		ext_edge_ok = ext_edge && armed_reg;
		ext_prev_next = ext_level;
		// Alignment stage; bypass skips it
		ext_edge_d_next = ext_edge_ok && !sync_bypass;
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			sync1_reg <= '0;
			sync2_reg <= '0;
			ext_prev_reg <= 1'b0;
			ext_edge_d_reg <= 1'b0;
		end else begin
			sync1_reg <= sync1_next;
			sync2_reg <= sync2_next;
			ext_prev_reg <= ext_prev_next;
			ext_edge_d_reg <= ext_edge_d_next;
		end
	end

	// ****************************************
	// Control registers
	// ****************************************
	always_comb begin
		timer_control_next = timer_control_reg;
		gate_control_next = gate_control_reg;
		system_clock_select_next = system_clock_select_reg;
		force_run_next = force_run_reg;
		if (reg_write) begin
			unique case (reg_addr)
				`GTC_ADDR_TIMER_CONTROL: timer_control_next = reg_wdata & `GTC_TC_WRITE_MASK;
				`GTC_ADDR_GATE_CONTROL: gate_control_next = reg_wdata & `GTC_GC_WRITE_MASK;
				`GTC_ADDR_OSC_CONTROL: system_clock_select_next = reg_wdata[`GTC_OC_SCS_MSB:`GTC_OC_SCS_LSB];
				`GTC_ADDR_OSC_CONTROL_TWO: force_run_next = reg_wdata[`GTC_OC2_FORCE_RUN];
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			timer_control_reg <= `GTC_RST_TIMER_CONTROL;
			gate_control_reg <= `GTC_RST_GATE_CONTROL;
			system_clock_select_reg <= `GTC_RST_SCS;
			force_run_reg <= 1'b0;
		end else begin
			timer_control_reg <= timer_control_next;
			gate_control_reg <= gate_control_next;
			system_clock_select_reg <= system_clock_select_next;
			force_run_reg <= force_run_next;
		end
	end

	// ****************************************
	// Enable, source select and counter
	// ****************************************
	always_comb begin
		gate_level = gate_control_reg[`GTC_GC_SOURCE] ? sync2_reg[`GTC_SYNC_COMP] : sync2_reg[`GTC_SYNC_GATE];
		gate_ok = (gate_level == gate_polarity);
		count_enable = timer_run && (!gate_enable_mode || gate_ok);
		// Core clocks stop in sleep
		instr_tick = (phase_reg == `GTC_INSTR_LAST_PHASE) && !sleep_mode;
		phase_next = phase_reg + `GTC_PHASE_STEP;
		unique case (clock_source_select)
			CS_SYS_OSC: src_tick = !sleep_mode;
			CS_INSTR_CLK: src_tick = instr_tick;
			CS_EXTERNAL: src_tick = sync_bypass ? ext_edge_ok : (ext_edge_d_reg && !sleep_mode);
			CS_RESERVED: src_tick = 1'b0;
		endcase
		presc_bus.tick = src_tick && count_enable && !wr_count;
		presc_bus.clear = wr_count;
		presc_bus.select = timer_control_reg[`GTC_TC_PRESC_MSB:`GTC_TC_PRESC_LSB];

		// Low level must be seen before first counted rise
		armed_next = armed_reg;
		if (!timer_run || wr_count) begin
			armed_next = 1'b0;
		end else if (!ext_level) begin
			armed_next = 1'b1;
		end

		ovf_event = presc_bus.out_tick && (count_reg == `GTC_COUNT_MAX);
		count_next = count_reg;
		if (wr_low) begin
			count_next = {count_reg[15:8], reg_wdata};
		end else if (wr_high) begin
			count_next = {reg_wdata, count_reg[7:0]};
		end else if (presc_bus.out_tick) begin
			count_next = count_reg + `GTC_COUNT_STEP;
		end
		// Hardware set wins over software clear
		overflow_next = ovf_event || (overflow_reg && !(wr_status && reg_wdata[`GTC_ST_OVERFLOW]));
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			count_reg <= `GTC_RST_COUNT;
			phase_reg <= `GTC_RST_PHASE;
			armed_reg <= 1'b0;
			overflow_reg <= 1'b0;
		end else begin
			count_reg <= count_next;
			phase_reg <= phase_next;
			armed_reg <= armed_next;
			overflow_reg <= overflow_next;
		end
	end

	gtc_prescaler u_prescaler (
		.clk(clk),
		.reset(reset),
		.bus(presc_bus.presc)
	);

	// ****************************************
	// Read data, oscillator and wake outputs
	// ****************************************
	always_comb begin
		rdata_next = `GTC_READ_IDLE;
		if (reg_read) begin
			unique case (reg_addr)
				`GTC_ADDR_COUNT_LOW: rdata_next = count_reg[7:0];
				`GTC_ADDR_COUNT_HIGH: rdata_next = count_reg[15:8];
				`GTC_ADDR_TIMER_CONTROL: rdata_next = timer_control_reg;
				`GTC_ADDR_GATE_CONTROL: begin
					rdata_next = gate_control_reg;
					rdata_next[`GTC_GC_LEVEL] = gate_level;
				end
				`GTC_ADDR_STATUS: rdata_next[`GTC_ST_OVERFLOW] = overflow_reg;
				`GTC_ADDR_OSC_CONTROL: rdata_next[`GTC_OC_SCS_MSB:`GTC_OC_SCS_LSB] = system_clock_select_reg;
				`GTC_ADDR_OSC_CONTROL_TWO: rdata_next[`GTC_OC2_FORCE_RUN] = force_run_reg;
				default: rdata_next = `GTC_READ_IDLE;
			endcase
		end
		// Shared oscillator, independent of sleep
		osc_run_next = secondary_osc_enable || (|other_secondary_osc_enable) || force_run_reg
			|| (system_clock_select_reg == `GTC_SCS_SECONDARY);
		xtal_out_next = osc_run_reg && !sync2_reg[`GTC_SYNC_XTAL];
		wake_next = ovf_event && sleep_mode;
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			rdata_reg <= `GTC_READ_IDLE;
			osc_run_reg <= 1'b0;
			xtal_out_reg <= 1'b0;
			wake_reg <= 1'b0;
		end else begin
			rdata_reg <= rdata_next;
			osc_run_reg <= osc_run_next;
			xtal_out_reg <= xtal_out_next;
			wake_reg <= wake_next;
		end
	end

	assign reg_rdata = rdata_reg;
	assign secondary_osc_run = osc_run_reg;
	assign crystal_output_pin = xtal_out_reg;
	assign overflow_flag = overflow_reg;
	assign wake_request = wake_reg;

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);

	a_run_off_hold: assert property (
		(!timer_run && !wr_count) |=> $stable(count_reg))
		else $error("count moved while run bit clear");

	a_gate_hold_count: assert property (
		(gate_enable_mode && !gate_ok && !wr_count) |=> $stable(count_reg))
		else $error("count moved while gate closed");

	a_byte_write_live: assert property (
		wr_low |=> (count_reg[7:0] == $past(reg_wdata)) && (count_reg[15:8] == $past(count_reg[15:8])))
		else $error("low byte write did not land in count");

	a_sys_osc_rate: assert property (
		(clock_source_select == CS_SYS_OSC && count_enable && presc_bus.select == 2'h0
			&& !sleep_mode && !wr_count) |=> count_reg == $past(count_reg) + `GTC_COUNT_STEP)
		else $error("oscillator source did not count every cycle");

	a_instr_phase_tick: assert property (
		(clock_source_select == CS_INSTR_CLK && presc_bus.tick) |-> phase_reg == `GTC_INSTR_LAST_PHASE)
		else $error("instruction clock tick off phase");

	a_arm_cleared: assert property (
		(!timer_run || wr_count) |=> !armed_reg ##0 !ext_edge_ok)
		else $error("edge armed without a fresh low level");

	a_sleep_stop_sync: assert property (
		(sleep_mode && !(sync_bypass && clock_source_select == CS_EXTERNAL)) |-> !presc_bus.tick)
		else $error("count ticked in sleep on a stopped source");

	a_ovf_flag_set: assert property (
		ovf_event |=> overflow_reg && (count_reg == `GTC_RST_COUNT))
		else $error("wrap did not set overflow flag");

	a_osc_run_req: assert property (
		(secondary_osc_enable || force_run_reg) |=> secondary_osc_run)
		else $error("secondary oscillator not running when requested");

	a_wake_cause: assert property (
		wake_request |-> $past(sleep_mode) && overflow_flag)
		else $error("wake without overflow in sleep");

	c_overflow_wrap: cover property (ovf_event);
	c_sleep_wake: cover property (wake_reg);
	c_bypass_edge: cover property (sync_bypass && clock_source_select == CS_EXTERNAL && presc_bus.tick);
	c_gate_hold: cover property (gate_enable_mode && !gate_ok && timer_run ##1 gate_ok);

endmodule

`default_nettype wire

// *** inc/gtc_regs.svh ***
`ifndef GTC_REGS_SVH
`define GTC_REGS_SVH

// ****************************************
// Register bus geometry
// ****************************************
`define GTC_ADDR_W 3
`define GTC_DATA_W 8

// ****************************************
// Register offsets
// ****************************************
`define GTC_ADDR_COUNT_LOW 3'h0
`define GTC_ADDR_COUNT_HIGH 3'h1
`define GTC_ADDR_TIMER_CONTROL 3'h2
`define GTC_ADDR_GATE_CONTROL 3'h3
`define GTC_ADDR_STATUS 3'h4
`define GTC_ADDR_OSC_CONTROL 3'h5
`define GTC_ADDR_OSC_CONTROL_TWO 3'h6

// ****************************************
// Field positions
// ****************************************
`define GTC_TC_RUN 0
`define GTC_TC_SYNC_BYPASS 2
`define GTC_TC_SOSC_EN 3
`define GTC_TC_PRESC_LSB 4
`define GTC_TC_PRESC_MSB 5
`define GTC_TC_CS_LSB 6
`define GTC_TC_CS_MSB 7
`define GTC_GC_LEVEL 4
`define GTC_GC_SOURCE 5
`define GTC_GC_POLARITY 6
`define GTC_GC_ENABLE 7
`define GTC_ST_OVERFLOW 0
`define GTC_OC_SCS_LSB 0
`define GTC_OC_SCS_MSB 1
`define GTC_OC2_FORCE_RUN 0

// ****************************************
// Write masks and reset values
// ****************************************
`define GTC_TC_WRITE_MASK 8'hFD
`define GTC_GC_WRITE_MASK 8'hE0
`define GTC_RST_TIMER_CONTROL 8'h00
`define GTC_RST_GATE_CONTROL 8'h00
`define GTC_RST_SCS 2'h0
`define GTC_RST_COUNT 16'h0000
`define GTC_RST_PRESC 3'h0
`define GTC_RST_PHASE 2'h0
`define GTC_READ_IDLE 8'h00

// ****************************************
// Codes and counts
// ****************************************
`define GTC_CS_CODE_INSTR 2'h0
`define GTC_CS_CODE_SYS 2'h1
`define GTC_CS_CODE_EXT 2'h2
`define GTC_CS_CODE_RSVD 2'h3
`define GTC_SCS_SECONDARY 2'h1
`define GTC_INSTR_LAST_PHASE 2'h3
`define GTC_PHASE_STEP 2'h1
`define GTC_COUNT_MAX 16'hFFFF
`define GTC_COUNT_STEP 16'h0001
`define GTC_PRESC_STEP 3'h1
`define GTC_PRESC_LAST_DIV1 3'h0
`define GTC_PRESC_LAST_DIV2 3'h1
`define GTC_PRESC_LAST_DIV4 3'h3
`define GTC_PRESC_LAST_DIV8 3'h7

// ****************************************
// Synchroniser lanes
// ****************************************
`define GTC_SYNC_W 4
`define GTC_SYNC_PIN 0
`define GTC_SYNC_XTAL 1
`define GTC_SYNC_GATE 2
`define GTC_SYNC_COMP 3

`endif

// *** inc/gtc_pkg.sv ***
`include "gtc_regs.svh"

package gtc_pkg;

	typedef enum logic [1:0] {
		CS_INSTR_CLK = `GTC_CS_CODE_INSTR,
		CS_SYS_OSC = `GTC_CS_CODE_SYS,
		CS_EXTERNAL = `GTC_CS_CODE_EXT,
		CS_RESERVED = `GTC_CS_CODE_RSVD
	} gtc_clk_src_t;

endpackage

// *** inc/gtc_presc_if.sv ***
`timescale 1ns/1ps
`default_nettype none

interface gtc_presc_if;
	logic tick;
	logic clear;
	logic [1:0] select;
	logic out_tick;

	modport core (output tick, output clear, output select, input out_tick);
	modport presc (input tick, input clear, input select, output out_tick);
endinterface

`default_nettype wire

// *** verilog/gtc_prescaler.sv ***
`timescale 1ns/1ps
`default_nettype none

module gtc_prescaler
	import gtc_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	gtc_presc_if.presc bus
);

	logic [2:0] count_reg;
	logic [2:0] count_next;
	logic [2:0] last_count;

	// ****************************************
	// Divide selected clock by 1, 2, 4 or 8
	// ****************************************
	always_comb begin
		unique case (bus.select)
			2'h0: last_count = `GTC_PRESC_LAST_DIV1;
			2'h1: last_count = `GTC_PRESC_LAST_DIV2;
			2'h2: last_count = `GTC_PRESC_LAST_DIV4;
			2'h3: last_count = `GTC_PRESC_LAST_DIV8;
		endcase
		bus.out_tick = bus.tick && !bus.clear && (count_reg >= last_count);
		count_next = count_reg;
		if (bus.clear) begin
			count_next = `GTC_RST_PRESC;
		end else if (bus.tick) begin
			// Stale count after a smaller select wraps at once
			count_next = (count_reg >= last_count) ? `GTC_RST_PRESC : count_reg + `GTC_PRESC_STEP;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			count_reg <= `GTC_RST_PRESC;
		end else begin
			count_reg <= count_next;
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	a_presc_clear_zero: assert property (@(posedge clk) disable iff (reset)
		bus.clear |=> count_reg == `GTC_RST_PRESC)
		else $error("prescale count not cleared by count write");

	a_presc_div_one: assert property (@(posedge clk) disable iff (reset)
		(bus.select == 2'h0 && bus.tick && !bus.clear) |-> bus.out_tick)
		else $error("divide by one dropped a tick");

	a_presc_div_eight: assert property (@(posedge clk) disable iff (reset)
		(bus.select == 2'h3 && bus.out_tick) |-> count_reg == `GTC_PRESC_LAST_DIV8)
		else $error("divide by eight emitted early");

endmodule

`default_nettype wire

// *** sim/gtc_pin_source.sv ***
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// Pin-side sources: count pin, crystal, gates
// ****************************************
module gtc_pin_source (
	input wire logic clk,
	output logic external_count_pin,
	output logic crystal_input_pin,
	output logic gate_pin,
	output logic comparator_gate
);
	initial begin
		external_count_pin = 1'b0;
		crystal_input_pin = 1'b0;
		gate_pin = 1'b0;
		comparator_gate = 1'b0;
	end

	// Line 0 pin, 1 crystal, 2 gate pin, 3 comparator
	// Lines change just after a rising edge
	task automatic set_line(input int which, input logic v);
		@(posedge clk);
		case (which)
			0: external_count_pin <= v;
			1: crystal_input_pin <= v;
			2: gate_pin <= v;
			default: comparator_gate <= v;
		endcase
	endtask

	// Low-to-high then back low; crystal stands low between bursts
	task automatic pulses(input int which, input int n, input int half_cycles);
		for (int i = 0; i < n; i++) begin
			repeat (half_cycles - 1) @(posedge clk);
			set_line(which, 1'b1);
			repeat (half_cycles - 1) @(posedge clk);
			set_line(which, 1'b0);
		end
	endtask
endmodule

`default_nettype wire

// *** sim/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "gtc_regs.svh"

module testbench
	import gtc_pkg::*;
;
	localparam logic [2:0] a_lo = `GTC_ADDR_COUNT_LOW;
	localparam logic [2:0] a_hi = `GTC_ADDR_COUNT_HIGH;
	localparam logic [2:0] a_tc = `GTC_ADDR_TIMER_CONTROL;
	localparam logic [2:0] a_gc = `GTC_ADDR_GATE_CONTROL;
	localparam logic [2:0] a_st = `GTC_ADDR_STATUS;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic [2:0] reg_addr = 3'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_write = 1'b0;
	logic reg_read = 1'b0;
	logic [7:0] reg_rdata;
	wire logic ext_pin, xtal, gate_pin, comp_gate;
	logic sleep_mode = 1'b0;
	logic [1:0] other_en = 2'h0;
	logic xtal_out, osc_run, overflow_flag, wake_request;
	int err_count = 0;
	int tests_run = 0;
	int wake_seen = 0;
	logic [15:0] cnt;
	logic [7:0] v;

	always #2.5 clk = ~clk;
	always @(posedge clk) if (wake_request === 1'b1) wake_seen++;

	gtc_pin_source gtc_pin_source_i (.clk(clk), .external_count_pin(ext_pin), .crystal_input_pin(xtal),
		.gate_pin(gate_pin), .comparator_gate(comp_gate));
	gtc_core gtc_core_i (.clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .external_count_pin(ext_pin),
		.crystal_input_pin(xtal), .gate_pin(gate_pin), .comparator_gate(comp_gate), .sleep_mode(sleep_mode),
		.other_secondary_osc_enable(other_en), .crystal_output_pin(xtal_out), .secondary_osc_run(osc_run),
		.overflow_flag(overflow_flag), .wake_request(wake_request));

	// ****************************************
	// Bus and compare helpers
	// ****************************************
	function automatic logic [7:0] tc(input logic [1:0] cs, input logic [1:0] ps, input logic sosc,
		input logic byp, input logic run);
		return {cs, ps, sosc, byp, 1'b0, run};
	endfunction

	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clk);
		reg_write <= 1'b0;
	endtask

	task automatic rd(input logic [2:0] a, output logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clk);
		reg_read <= 1'b0;
		#1 d = reg_rdata;
	endtask

	task automatic rd_count(output logic [15:0] c);
		rd(a_lo, c[7:0]);
		rd(a_hi, c[15:8]);
	endtask

	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic near(input string what, input int exp, input int tol, input logic [15:0] got);
		tests_run++;
		if ((^got === 1'bx) || (int'(got) < exp - tol) || (int'(got) > exp + tol)) begin
			err_count++;
			$display("BAD %s expected %0d seen %h", what, exp, got);
		end
	endtask

	task automatic run_for(input logic [7:0] ctrl, input int cycles, output logic [15:0] c);
		wr(a_hi, 8'h00);
		wr(a_lo, 8'h00);
		wr(a_tc, ctrl);
		repeat (cycles) @(posedge clk);
		wr(a_tc, ctrl & 8'hFE);
		rd_count(c);
	endtask

	task automatic run_ext(input logic [7:0] ctrl, input int which, input int n, output logic [15:0] c);
		wr(a_hi, 8'h00);
		wr(a_lo, 8'h00);
		wr(a_tc, ctrl);
		gtc_pin_source_i.pulses(which, n, 4);
		repeat (8) @(posedge clk);
		wr(a_tc, ctrl & 8'hFE);
		rd_count(c);
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_regs();
		for (int a = 0; a < 8; a++) begin
			rd(a[2:0], v);
			check("reset value", 16'h0000, {8'h00, v});
		end
		wr(a_tc, 8'hFF);
		rd(a_tc, v);
		check("control mask", 16'h00FD, {8'h00, v});
		wr(a_tc, 8'h00);
		wr(3'h7, 8'hA5);
		rd(3'h7, v);
		check("unmapped", 16'h0000, {8'h00, v});
		wr(a_lo, 8'h55);
		wr(a_hi, 8'hAA);
		rd_count(cnt);
		check("count write", 16'hAA55, cnt);
	endtask

	task automatic t_internal();
		run_for(tc(2'h1, 2'h0, 1'b0, 1'b0, 1'b0), 62, cnt);
		check("run clear", 16'h0000, cnt);
		for (int p = 0; p < 4; p++) begin
			run_for(tc(2'h1, p[1:0], 1'b0, 1'b0, 1'b1), 62, cnt);
			near("osc prescaled", 64 >> p, 2, cnt);
		end
		run_for(tc(2'h0, 2'h0, 1'b0, 1'b0, 1'b1), 62, cnt);
		near("instr clock", 16, 2, cnt);
		run_for(tc(2'h3, 2'h0, 1'b0, 1'b0, 1'b1), 62, cnt);
		check("reserved source", 16'h0000, cnt);
	endtask

	task automatic t_presc_clear();
		for (int k = 0; k < 8; k++) begin
			wr(a_hi, 8'h00);
			wr(a_tc, tc(2'h1, 2'h3, 1'b0, 1'b0, 1'b1));
			repeat (3 + k) @(posedge clk);
			wr(a_lo, 8'h00);
			repeat (3) @(posedge clk);
			rd(a_lo, v);
			check("prescaler cleared", 16'h0000, {8'h00, v});
			wr(a_tc, 8'h00);
		end
	endtask

	task automatic t_gate();
		wr(a_gc, 8'hC0);
		run_for(tc(2'h1, 2'h0, 1'b0, 1'b0, 1'b1), 62, cnt);
		check("gate held", 16'h0000, cnt);
		gtc_pin_source_i.set_line(2, 1'b1);
		run_for(tc(2'h1, 2'h0, 1'b0, 1'b0, 1'b1), 62, cnt);
		near("gate open", 64, 2, cnt);
		wr(a_gc, 8'h80);
		run_for(tc(2'h1, 2'h0, 1'b0, 1'b0, 1'b1), 62, cnt);
		check("low polarity", 16'h0000, cnt);
		gtc_pin_source_i.set_line(2, 1'b0);
		gtc_pin_source_i.set_line(3, 1'b1);
		wr(a_gc, 8'hE0);
		run_for(tc(2'h1, 2'h0, 1'b0, 1'b0, 1'b1), 62, cnt);
		near("comparator gate", 64, 2, cnt);
		gtc_pin_source_i.set_line(3, 1'b0);
		wr(a_gc, 8'h00);
	endtask

	task automatic t_external();
		run_ext(tc(2'h2, 2'h0, 1'b0, 1'b0, 1'b1), 0, 10, cnt);
		check("pin edges", 16'd10, cnt);
		run_ext(tc(2'h2, 2'h0, 1'b0, 1'b1, 1'b1), 0, 7, cnt);
		check("bypass edges", 16'd7, cnt);
		run_ext(tc(2'h2, 2'h1, 1'b0, 1'b0, 1'b1), 0, 8, cnt);
		check("pin prescaled", 16'd4, cnt);
		gtc_pin_source_i.set_line(0, 1'b1);
		run_for(tc(2'h2, 2'h0, 1'b0, 1'b0, 1'b1), 20, cnt);
		check("no edge without low", 16'h0000, cnt);
		gtc_pin_source_i.set_line(0, 1'b0);
		wr(a_tc, tc(2'h2, 2'h0, 1'b1, 1'b0, 1'b0));
		repeat (2) @(posedge clk);
		check("osc started", 16'h0001, {15'h0000, osc_run});
		repeat (40) @(posedge clk);
		check("crystal drive", 16'h0001, {15'h0000, xtal_out});
		wr(a_hi, 8'h00);
		wr(a_lo, 8'h00);
		wr(a_tc, tc(2'h2, 2'h0, 1'b1, 1'b0, 1'b1));
		gtc_pin_source_i.pulses(0, 5, 4);
		gtc_pin_source_i.pulses(1, 4, 5);
		repeat (8) @(posedge clk);
		wr(a_tc, 8'h00);
		rd_count(cnt);
		check("crystal edges", 16'd4, cnt);
	endtask

	task automatic t_osc_run();
		repeat (2) @(posedge clk);
		check("osc idle", 16'h0000, {15'h0000, osc_run});
		other_en <= 2'h2;
		repeat (3) @(posedge clk);
		check("sibling enable", 16'h0001, {15'h0000, osc_run});
		other_en <= 2'h0;
		wr(3'h6, 8'h01);
		repeat (2) @(posedge clk);
		check("force run", 16'h0001, {15'h0000, osc_run});
		wr(3'h6, 8'h00);
		wr(3'h5, 8'h01);
		repeat (2) @(posedge clk);
		check("system select", 16'h0001, {15'h0000, osc_run});
		wr(3'h5, 8'h02);
		repeat (2) @(posedge clk);
		check("other select", 16'h0000, {15'h0000, osc_run});
		wr(3'h5, 8'h00);
	endtask

	task automatic t_overflow();
		wr(a_hi, 8'hFF);
		wr(a_lo, 8'hFE);
		wr(a_tc, tc(2'h1, 2'h0, 1'b0, 1'b0, 1'b1));
		repeat (6) @(posedge clk);
		wr(a_tc, 8'h00);
		rd_count(cnt);
		near("wrapped count", 6, 3, cnt);
		rd(a_st, v);
		check("overflow status", 16'h0001, {8'h00, v});
		wr(a_st, 8'h01);
		#1 check("overflow cleared", 16'h0000, {15'h0000, overflow_flag});
		wr(a_hi, 8'hFF);
		wr(a_lo, 8'hFF);
		sleep_mode <= 1'b1;
		wr(a_tc, tc(2'h2, 2'h0, 1'b0, 1'b0, 1'b1));
		gtc_pin_source_i.pulses(0, 2, 4);
		repeat (8) @(posedge clk);
		rd_count(cnt);
		check("sync sleeps", 16'hFFFF, cnt);
		wr(a_tc, tc(2'h2, 2'h0, 1'b0, 1'b1, 1'b1));
		gtc_pin_source_i.pulses(0, 2, 4);
		repeat (8) @(posedge clk);
		rd_count(cnt);
		near("async in sleep", 1, 1, cnt);
		check("wake pulse", 16'h0001, wake_seen[15:0]);
		check("sleep overflow", 16'h0001, {15'h0000, overflow_flag});
		wr(a_tc, 8'h00);
		sleep_mode <= 1'b0;
		wr(a_st, 8'h01);
	endtask

	// ****************************************
	// Verdict, watchdog, main sequence
	// ****************************************
	task automatic end_of_test();
		$display("Checks %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask

	initial begin
		#200000;
		err_count++;
		end_of_test();
	end

	initial begin
		repeat (6) @(posedge clk);
		reset <= 1'b0;
		t_regs();
		t_internal();
		t_presc_clear();
		t_gate();
		t_external();
		t_osc_run();
		t_overflow();
		end_of_test();
	end
endmodule

`default_nettype wire
